// *** hdl/sibp_port.sv ***
// Serial management target port: indexed block write and block read, output-enable gating.
// Assumes the link logic runs on the differential input reference clock and the output gating on clk.
// Functional notes
// - The port answers only the seven-bit address 1101101 followed by the read/write bit.
// - The port acknowledges the address, index and count bytes of a block write.
// - Every data byte received in a block write is acknowledged.
// - After the repeated start the address with the read bit is acknowledged before data returns.
// - The read returns the count byte first, then the registers from N onward.
// - A not-acknowledge then stop ends a read and the port releases the data line.
// - Register 0 holds enable bits for output 1 at bit 5 and output 0 at bit 3, both reset to one.
// - A cleared enable bit holds its output low whatever the active-low gate pin does.
// - The port serves transfers only while the reference clock runs.
`timescale 1ns/1ps
module sibp_port (
	input wire logic clk,
	input wire logic reset,
	input wire logic refClk,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeN,
	input wire logic oe0PinN,
	input wire logic oe1PinN,
	output logic output0_drive_enable,
	output logic output1_drive_enable
);

	// ************************************************************
	// Link domain reset and pin sampling
	// ************************************************************
	// Whole link side stalls with the reference clock, so no transfer is serviced then
	logic linkReset;
	logic sclS;
	logic sdaS;
	logic prevScl;
	logic prevSda;
	logic next_prevScl;
	logic next_prevSda;

	sibp_sync #(.WIDTH(1)) u_resetSync (
		.clk(refClk),
		.din(reset),
		.dout(linkReset)
	);

	sibp_sync #(.WIDTH(2)) u_pinSync (
		.clk(refClk),
		.din({sclIn, sdaIn}),
		.dout({sclS, sdaS})
	);

	always_comb
	begin
		next_prevScl = sclS;
		next_prevSda = sdaS;
	end

	always_ff @(posedge refClk)
	begin
		prevScl <= next_prevScl;
		prevSda <= next_prevSda;
	end

	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	assign sclRise = sclS && !prevScl;
	assign sclFall = !sclS && prevScl;
	assign startSeen = sclS && prevScl && prevSda && !sdaS;
	assign stopSeen = sclS && prevScl && !prevSda && sdaS;

	// ************************************************************
	// Transfer engine
	// ************************************************************
	sibp_pkg::sibp_state_t state;
	sibp_pkg::sibp_state_t next_state;
	logic [3:0] bitCnt;
	logic [3:0] next_bitCnt;
	logic [7:0] shiftIn;
	logic [7:0] next_shiftIn;
	logic [7:0] txByte;
	logic [7:0] next_txByte;
	logic [7:0] index;
	logic [7:0] next_index;
	logic [7:0] rdPtr;
	logic [7:0] next_rdPtr;
	logic isRead;
	logic next_isRead;
	logic next_sdaOeN;
	logic next_sdaOut;
	sibp_pkg::sibp_wr_t wrReq;
	sibp_pkg::sibp_wr_t next_wrReq;
	logic [7:0] rdData;
	logic [7:0] oeByte;
	logic byteIn;
	logic byteDone;

	assign byteIn = sclRise && bitCnt < sibp_pkg::BYTE_BITS;
	assign byteDone = sclFall && bitCnt == sibp_pkg::BYTE_BITS;

	always_comb
	begin
		next_state = state;
		next_bitCnt = bitCnt;
		next_shiftIn = shiftIn;
		next_txByte = txByte;
		next_index = index;
		next_rdPtr = rdPtr;
		next_isRead = isRead;
		next_sdaOeN = sdaOeN;
		next_sdaOut = 1'b0;
		next_wrReq = '0;
		if (startSeen)
		begin
			// Repeated start keeps the index so a read resumes from N
			next_state = sibp_pkg::ST_ADDR;
			next_bitCnt = sibp_pkg::BIT_ZERO;
			next_sdaOeN = 1'b1;
		end
		else if (stopSeen)
		begin
			next_state = sibp_pkg::ST_IDLE;
			next_sdaOeN = 1'b1;
		end
		else
		begin
			case (state)
				sibp_pkg::ST_ADDR, sibp_pkg::ST_INDEX, sibp_pkg::ST_COUNT, sibp_pkg::ST_WDATA:
				begin
					if (byteIn)
					begin
						next_shiftIn = {shiftIn[6:0], sdaS};
						next_bitCnt = bitCnt + sibp_pkg::BIT_ONE;
					end
					else if (byteDone && state == sibp_pkg::ST_ADDR)
					begin
						if (shiftIn[7:1] == sibp_pkg::DEV_ADDR)
						begin
							next_state = sibp_pkg::ST_ADDR_ACK;
							next_sdaOeN = 1'b0;
							next_isRead = shiftIn[0];
							next_txByte = sibp_pkg::READ_COUNT;
						end
						else
						begin
							next_state = sibp_pkg::ST_IGNORE;
						end
					end
					else if (byteDone && state == sibp_pkg::ST_INDEX)
					begin
						next_index = shiftIn;
						next_rdPtr = shiftIn;
						next_state = sibp_pkg::ST_INDEX_ACK;
						next_sdaOeN = 1'b0;
					end
					else if (byteDone && state == sibp_pkg::ST_COUNT)
					begin
						// Count is acknowledged; every following byte is issued as a write, X only tells the length
						next_state = sibp_pkg::ST_COUNT_ACK;
						next_sdaOeN = 1'b0;
					end
					else if (byteDone)
					begin
						next_wrReq = '{we: 1'b1, index: index, data: shiftIn};
						next_index = index + sibp_pkg::INDEX_STEP;
						next_state = sibp_pkg::ST_WDATA_ACK;
						next_sdaOeN = 1'b0;
					end
				end
				sibp_pkg::ST_ADDR_ACK, sibp_pkg::ST_INDEX_ACK, sibp_pkg::ST_COUNT_ACK, sibp_pkg::ST_WDATA_ACK:
				begin
					if (sclFall)
					begin
						next_bitCnt = sibp_pkg::BIT_ZERO;
						next_sdaOeN = 1'b1;
						case (state)
							sibp_pkg::ST_ADDR_ACK:
							begin
								if (isRead)
								begin
									// First data bit goes out on the edge that ends the acknowledge
									next_state = sibp_pkg::ST_RDATA;
									next_sdaOeN = txByte[7];
									next_txByte = {txByte[6:0], 1'b0};
								end
								else
								begin
									next_state = sibp_pkg::ST_INDEX;
								end
							end
							sibp_pkg::ST_INDEX_ACK:
							begin
								next_state = sibp_pkg::ST_COUNT;
							end
							default:
							begin
								next_state = sibp_pkg::ST_WDATA;
							end
						endcase
					end
				end
				sibp_pkg::ST_RDATA:
				begin
					if (sclRise)
					begin
						next_bitCnt = bitCnt + sibp_pkg::BIT_ONE;
					end
					else if (byteDone)
					begin
						next_state = sibp_pkg::ST_RACK;
						next_bitCnt = sibp_pkg::BIT_ZERO;
						next_sdaOeN = 1'b1;
					end
					else if (sclFall)
					begin
						next_sdaOeN = txByte[7];
						next_txByte = {txByte[6:0], 1'b0};
					end
				end
				sibp_pkg::ST_RACK:
				begin
					if (sclRise && sdaS)
					begin
						next_state = sibp_pkg::ST_IGNORE;
					end
					else if (sclRise)
					begin
						next_bitCnt = sibp_pkg::BIT_ONE;
					end
					else if (sclFall && bitCnt == sibp_pkg::BIT_ONE)
					begin
						next_state = sibp_pkg::ST_RDATA;
						next_bitCnt = sibp_pkg::BIT_ZERO;
						next_sdaOeN = rdData[7];
						next_txByte = {rdData[6:0], 1'b0};
						next_rdPtr = rdPtr + sibp_pkg::INDEX_STEP;
					end
				end
				sibp_pkg::ST_IDLE, sibp_pkg::ST_IGNORE:
				begin
					next_sdaOeN = 1'b1;
				end
				default:
				begin
					next_state = sibp_pkg::ST_IDLE;
					next_sdaOeN = 1'b1;
				end
			endcase
		end
		if (linkReset)
		begin
			next_state = sibp_pkg::ST_IDLE;
			next_bitCnt = sibp_pkg::BIT_ZERO;
			next_shiftIn = '0;
			next_txByte = '0;
			next_index = sibp_pkg::REG_OE_INDEX;
			next_rdPtr = sibp_pkg::REG_OE_INDEX;
			next_isRead = 1'b0;
			next_sdaOeN = 1'b1;
			next_wrReq = '0;
		end
	end

	always_ff @(posedge refClk)
	begin
		state <= next_state;
		bitCnt <= next_bitCnt;
		shiftIn <= next_shiftIn;
		txByte <= next_txByte;
		index <= next_index;
		rdPtr <= next_rdPtr;
		isRead <= next_isRead;
		sdaOeN <= next_sdaOeN;
		sdaOut <= next_sdaOut;
		wrReq <= next_wrReq;
	end

	sibp_regs u_regs (
		.clk(refClk),
		.reset(linkReset),
		.wr(wrReq),
		.rdIndex(rdPtr),
		.rdData(rdData),
		.oeByte(oeByte)
	);

	// ************************************************************
	// Output gating on the core clock
	// ************************************************************
	logic [1:0] enSync;
	logic [1:0] pinSyncN;
	logic next_out0;
	logic next_out1;

	sibp_sync #(.WIDTH(4)) u_gateSync (
		.clk(clk),
		.din({oeByte[sibp_pkg::OE1_BIT], oeByte[sibp_pkg::OE0_BIT], oe1PinN, oe0PinN}),
		.dout({enSync, pinSyncN})
	);

	always_comb
	begin
		next_out0 = enSync[0] && !pinSyncN[0];
		next_out1 = enSync[1] && !pinSyncN[1];
		if (reset)
		begin
			next_out0 = 1'b0;
			next_out1 = 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		output0_drive_enable <= next_out0;
		output1_drive_enable <= next_out1;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	a_oe_bit_overrides: assert property (@(posedge clk) disable iff (reset)
		(!enSync[0] || !enSync[1]) |=> !(output0_drive_enable && !$past(enSync[0])) &&
		!(output1_drive_enable && !$past(enSync[1])))
		else $error("cleared enable bit did not hold output low");

	a_addr_match_ack: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_ADDR && byteDone && !startSeen && !stopSeen &&
		shiftIn[7:1] == sibp_pkg::DEV_ADDR) |=> state == sibp_pkg::ST_ADDR_ACK && !sdaOeN)
		else $error("matching address not acknowledged");

	a_addr_miss_ignore: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_ADDR && byteDone && !startSeen && !stopSeen &&
		shiftIn[7:1] != sibp_pkg::DEV_ADDR) |=> state == sibp_pkg::ST_IGNORE && sdaOeN)
		else $error("foreign address was acknowledged");

	a_ignore_quiet: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_IGNORE) ##1 (state == sibp_pkg::ST_IGNORE) |-> sdaOeN)
		else $error("data line driven while ignoring a transfer");

	a_index_ack: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_INDEX && byteDone && !startSeen && !stopSeen) |=>
		state == sibp_pkg::ST_INDEX_ACK && !sdaOeN && index == $past(shiftIn))
		else $error("index byte not acknowledged or not captured");

	a_data_ack_store: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_WDATA && byteDone && !startSeen && !stopSeen) |=>
		!sdaOeN && wrReq.we && wrReq.data == $past(shiftIn) && index == $past(index) + sibp_pkg::INDEX_STEP)
		else $error("data byte not acknowledged or not stored in order");

	a_count_first: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_ADDR_ACK && isRead && sclFall && !startSeen && !stopSeen) |=>
		state == sibp_pkg::ST_RDATA && sdaOeN == sibp_pkg::READ_COUNT[7])
		else $error("read did not open with the count byte");

	a_nack_release: assert property (@(posedge refClk) disable iff (linkReset)
		(state == sibp_pkg::ST_RACK && sclRise && sdaS && !startSeen && !stopSeen) |=>
		(state == sibp_pkg::ST_IGNORE && sdaOeN) [*2])
		else $error("data line not released after not-acknowledge");

	a_stop_idle: assert property (@(posedge refClk) disable iff (linkReset)
		stopSeen |=> state == sibp_pkg::ST_IDLE && sdaOeN)
		else $error("stop did not return the port to idle");

endmodule : sibp_port

// *** pkg/sibp_pkg.sv ***
// Shared constants and types for the serial management target port.
// Assumes a byte-wide register space reached only through indexed block transfers.
package sibp_pkg;

	// ************************************************************
	// Bus address and transfer framing
	// ************************************************************
	localparam logic [6:0] DEV_ADDR = 7'h6d;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	// Count byte sent ahead of read data; the count register itself is not part of this port
	localparam logic [7:0] READ_COUNT = 8'h08;
	localparam logic [7:0] INDEX_STEP = 8'h01;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] REG_OE_INDEX = 8'h00;
	localparam int OE1_BIT = 5;
	localparam int OE0_BIT = 3;
	localparam logic [7:0] OE_RESET = 8'h2c;
	localparam logic [7:0] OE_WRITE_MASK = 8'h28;
	localparam logic [7:0] OE_FIXED_ONES = 8'h04;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [11:0] {
		ST_IDLE = 12'h001,
		ST_ADDR = 12'h002,
		ST_ADDR_ACK = 12'h004,
		ST_INDEX = 12'h008,
		ST_INDEX_ACK = 12'h010,
		ST_COUNT = 12'h020,
		ST_COUNT_ACK = 12'h040,
		ST_WDATA = 12'h080,
		ST_WDATA_ACK = 12'h100,
		ST_RDATA = 12'h200,
		ST_RACK = 12'h400,
		ST_IGNORE = 12'h800
	} sibp_state_t;

	typedef struct packed {
		logic we;
		logic [7:0] index;
		logic [7:0] data;
	} sibp_wr_t;

endpackage : sibp_pkg

// *** hdl/sibp_sync.sv ***
// Two-flop level synchroniser, one lane per bit.
// Assumes each lane is a slow level; multi-bit lanes are not coherent with each other.
`timescale 1ns/1ps
module sibp_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_dout;

	always_comb
	begin
		next_stage1 = din;
		next_dout = stage1;
	end

	always_ff @(posedge clk)
	begin
		stage1 <= next_stage1;
		dout <= next_dout;
	end

endmodule : sibp_sync

// *** hdl/sibp_regs.sv ***
// Byte register space of the port, with registered read data.
// Assumes writes arrive one per cycle on the link clock; only the output-enable byte is stored.
`timescale 1ns/1ps
module sibp_regs (
	input wire logic clk,
	input wire logic reset,
	input wire sibp_pkg::sibp_wr_t wr,
	input wire logic [7:0] rdIndex,
	output logic [7:0] rdData,
	output logic [7:0] oeByte
);

	logic [7:0] next_oeByte;
	logic [7:0] next_rdData;

	always_comb
	begin
		next_oeByte = oeByte;
		if (wr.we && wr.index == sibp_pkg::REG_OE_INDEX)
		begin
			// Reserved bits keep their fixed values whatever is written
			next_oeByte = (wr.data & sibp_pkg::OE_WRITE_MASK) | sibp_pkg::OE_FIXED_ONES;
		end
		next_rdData = (rdIndex == sibp_pkg::REG_OE_INDEX) ? oeByte : sibp_pkg::UNMAPPED_READ;
		if (reset)
		begin
			next_oeByte = sibp_pkg::OE_RESET;
			next_rdData = sibp_pkg::UNMAPPED_READ;
		end
	end

	always_ff @(posedge clk)
	begin
		oeByte <= next_oeByte;
		rdData <= next_rdData;
	end

	a_oe_write_store: assert property (@(posedge clk) disable iff (reset)
		(wr.we && wr.index == sibp_pkg::REG_OE_INDEX) |=>
		oeByte == (($past(wr.data) & sibp_pkg::OE_WRITE_MASK) | sibp_pkg::OE_FIXED_ONES))
		else $error("output enable byte not updated by write");

	a_read_data_path: assert property (@(posedge clk) disable iff (reset)
		(rdIndex == sibp_pkg::REG_OE_INDEX && !wr.we) ##1 (!wr.we) |-> rdData == oeByte)
		else $error("read data does not follow output enable byte");

endmodule : sibp_regs

// *** tb/sibp_host_model.sv ***
// Bus host model: drives the bus clock line and pulls the data line low as a host would.
// Assumes the bench resolves the wired data line with its pull-up and feeds it back as sdaWire.
`timescale 1ns/1ps
module sibp_host_model (
	input wire logic clk,
	input wire logic sdaWire,
	output logic scl,
	output logic sdaLow
);
	// ************************************************************
	// Bus phases
	// ************************************************************
	// Phase of 200 ns, a third of a data bit, keeps scl far slower than the link synchroniser
	localparam int HALF = 20;

	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic waitClk(input int n);
		repeat (n) @(negedge clk);
	endtask : waitClk

	// Data moves only mid way through scl low, never beside an scl edge
	task automatic bitCycle(input logic pull, output logic seen);
		waitClk(HALF);
		sdaLow = pull;
		waitClk(HALF);
		scl = 1'b1;
		waitClk(HALF);
		seen = sdaWire;
		scl = 1'b0;
	endtask : bitCycle

	task automatic startCond();
		waitClk(HALF);
		sdaLow = 1'b0;
		waitClk(HALF);
		scl = 1'b1;
		waitClk(HALF);
		sdaLow = 1'b1;
		waitClk(HALF);
		scl = 1'b0;
	endtask : startCond

	task automatic stopCond();
		waitClk(HALF);
		sdaLow = 1'b1;
		waitClk(HALF);
		scl = 1'b1;
		waitClk(HALF);
		sdaLow = 1'b0;
		waitClk(HALF);
	endtask : stopCond

	task automatic sendByte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bitCycle(!b[i], s);
		end
		bitCycle(1'b0, s);
		ack = !s;
	endtask : sendByte

	task automatic recvByte(input logic ackIt, output logic [7:0] b);
		logic s;
		for (int i = 0; i < 8; i++)
		begin
			bitCycle(1'b0, s);
			b = {b[6:0], s};
		end
		bitCycle(ackIt, s);
	endtask : recvByte
endmodule : sibp_host_model

// *** tb/testbench.sv ***
// Self-checking bench for the serial management target port.
// Assumes the host model above; the link clock runs at 12 ns, unrelated to the core clock.
`timescale 1ns/1ps
module testbench;
	logic clk;
	logic refClk;
	logic refRun;
	logic reset;
	logic oe0PinN;
	logic oe1PinN;
	logic sdaOut;
	logic sdaOeN;
	logic en0;
	logic en1;
	logic scl;
	logic sdaLow;
	logic sdaWire;
	int mismatches;
	int checks_done;

	// Open-drain data line with pull-up
	assign sdaWire = !((!sdaOeN && !sdaOut) || sdaLow);

	// ************************************************************
	// Clocks and instances
	// ************************************************************
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Stopping the link clock parks it low
	initial
	begin
		refClk = 1'b0;
		#3;
		forever #6 refClk = refRun ? ~refClk : 1'b0;
	end

	sibp_port u_sibp_port (
		.clk(clk),
		.reset(reset),
		.refClk(refClk),
		.sclIn(scl),
		.sdaIn(sdaWire),
		.sdaOut(sdaOut),
		.sdaOeN(sdaOeN),
		.oe0PinN(oe0PinN),
		.oe1PinN(oe1PinN),
		.output0_drive_enable(en0),
		.output1_drive_enable(en1)
	);

	sibp_host_model u_sibp_host_model (
		.clk(clk),
		.sdaWire(sdaWire),
		.scl(scl),
		.sdaLow(sdaLow)
	);

	// ************************************************************
	// Checking and transfer tasks
	// ************************************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want)
		begin
			mismatches++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	function automatic logic [7:0] regVal(input logic [7:0] d);
		return (d & sibp_pkg::OE_WRITE_MASK) | sibp_pkg::OE_FIXED_ONES;
	endfunction : regVal

	task automatic blockWrite(input logic [6:0] addr, input logic [7:0] idx, input logic [7:0] d [$],
		input logic expAck);
		logic ack;
		u_sibp_host_model.startCond();
		u_sibp_host_model.sendByte({addr, 1'b0}, ack);
		check(8'(ack), 8'(expAck));
		u_sibp_host_model.sendByte(idx, ack);
		check(8'(ack), 8'(expAck));
		u_sibp_host_model.sendByte(8'(d.size()), ack);
		check(8'(ack), 8'(expAck));
		foreach (d[i])
		begin
			u_sibp_host_model.sendByte(d[i], ack);
			check(8'(ack), 8'(expAck));
		end
		u_sibp_host_model.stopCond();
		check(8'(sdaOeN), 8'h01);
	endtask : blockWrite

	task automatic blockRead(input logic [7:0] idx, input logic [7:0] want [$]);
		logic ack;
		logic [7:0] b;
		u_sibp_host_model.startCond();
		u_sibp_host_model.sendByte({sibp_pkg::DEV_ADDR, 1'b0}, ack);
		check(8'(ack), 8'h01);
		u_sibp_host_model.sendByte(idx, ack);
		check(8'(ack), 8'h01);
		u_sibp_host_model.startCond();
		u_sibp_host_model.sendByte({sibp_pkg::DEV_ADDR, 1'b1}, ack);
		check(8'(ack), 8'h01);
		// Open drain: the value pin must stay low so only the enable moves the line
		check(8'(sdaOut), 8'h00);
		u_sibp_host_model.recvByte(1'b1, b);
		check(b, sibp_pkg::READ_COUNT);
		foreach (want[i])
		begin
			u_sibp_host_model.recvByte(i != want.size() - 1, b);
			check(b, want[i]);
		end
		u_sibp_host_model.stopCond();
		check(8'(sdaOeN), 8'h01);
	endtask : blockRead

	task automatic outCheck(input logic e0, input logic e1);
		repeat (20) @(negedge clk);
		check(8'(en0), 8'(e0));
		check(8'(en1), 8'(e1));
	endtask : outCheck

	// ************************************************************
	// Run limit and main sequence
	// ************************************************************
	initial
	begin
		repeat (95000) @(posedge clk);
		mismatches++;
		$display("ERROR at %0t: run limit reached", $time);
		results();
	end

	initial
	begin
		mismatches = 0;
		checks_done = 0;
		reset = 1'b1;
		refRun = 1'b1;
		oe0PinN = 1'b0;
		oe1PinN = 1'b0;
		repeat (8) @(negedge clk);
		reset = 1'b0;
		repeat (10) @(negedge clk);
		outCheck(1'b1, 1'b1);
		blockRead(8'h00, '{sibp_pkg::OE_RESET, sibp_pkg::UNMAPPED_READ});
		blockWrite(sibp_pkg::DEV_ADDR, 8'h00, '{8'h00}, 1'b1);
		outCheck(1'b0, 1'b0);
		blockRead(8'h00, '{regVal(8'h00)});
		// Second byte lands at index 1, which holds nothing
		blockWrite(sibp_pkg::DEV_ADDR, 8'h00, '{8'hff, 8'h55}, 1'b1);
		blockRead(8'h00, '{regVal(8'hff), sibp_pkg::UNMAPPED_READ, sibp_pkg::UNMAPPED_READ});
		blockWrite(sibp_pkg::DEV_ADDR, 8'h00, '{8'h20}, 1'b1);
		outCheck(1'b0, 1'b1);
		oe1PinN = 1'b1;
		outCheck(1'b0, 1'b0);
		oe1PinN = 1'b0;
		oe0PinN = 1'b1;
		outCheck(1'b0, 1'b1);
		oe0PinN = 1'b0;
		blockWrite(sibp_pkg::DEV_ADDR ^ 7'h01, 8'h00, '{8'hff}, 1'b0);
		blockRead(8'h00, '{regVal(8'h20)});
		refRun = 1'b0;
		blockWrite(sibp_pkg::DEV_ADDR, 8'h00, '{8'hff}, 1'b0);
		refRun = 1'b1;
		repeat (10) @(negedge clk);
		blockRead(8'h00, '{regVal(8'h20)});
		blockWrite(sibp_pkg::DEV_ADDR, 8'h00, '{8'h28}, 1'b1);
		outCheck(1'b1, 1'b1);
		results();
	end
endmodule : testbench
